// file: inc/flag_bank_pkg.sv
// package: register map, field layout and bus types for the interrupt flag bank
package flag_bank_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 16;

    // word addresses (byte address = 4 * word)
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_THIRD = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h3;

    // implemented bits of each flag register
    localparam logic [FLAG_W-1:0] FIRST_IMPL = 16'h000B;
    localparam logic [FLAG_W-1:0] THIRD_IMPL = 16'h39FF;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
    localparam logic [1:0] EVENT_RESET = 2'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // first register bit positions
    localparam int BIT_INPUT_CHANGE = 3;
    localparam int BIT_PORT1_MASTER = 1;
    localparam int BIT_PORT1_SLAVE = 0;
    // event status bits: a flag rose in first / third register
    localparam int EV_FIRST = 0;
    localparam int EV_THIRD = 1;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_s;

    typedef struct packed {
        logic [FLAG_W-1:0] first;
        logic [FLAG_W-1:0] third;
    } flag_pair_s;
endpackage : flag_bank_pkg

// file: rtl/flag_bank.sv
// interrupt flag bank: two flag registers, event status, mask and irq, Avalon-MM slave
`timescale 1ns/1ps
module flag_bank (
    input wire logic core_clk, // 50 MHz system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [flag_bank_pkg::ADDR_W-1:0] avs_address, // word address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [flag_bank_pkg::DATA_W-1:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [flag_bank_pkg::DATA_W-1:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall, high until answer cycle
    input wire logic input_change_req, // input change notification event
    input wire logic port1_master_req, // first port master event
    input wire logic port1_slave_req, // first port slave event
    input wire logic [flag_bank_pkg::FLAG_W-1:0] third_req, // third register sources by bit
    output flag_bank_pkg::flag_pair_s flags_out, // flags to processor interrupt logic
    output logic irq // level, any unmasked event bit set
);
    import flag_bank_pkg::*;

    typedef struct packed {
        bus_state_e bus;
        logic [DATA_W-1:0] rdata;
        logic wait_n;
        logic [1:0] events;
        logic [1:0] mask;
        logic irq;
        flag_pair_s flags;
    } bank_state_s;

    bank_state_s state_reg;
    bank_state_s state_next;

    logic [FLAG_W-1:0] first_set;
    logic [FLAG_W-1:0] first_flags;
    logic [FLAG_W-1:0] third_flags;
    logic [FLAG_W-1:0] first_rose;
    logic [FLAG_W-1:0] third_rose;
    logic [FLAG_W-1:0] lane_mask;
    logic take;
    logic wr_first;
    logic wr_third;

    always_comb begin
        first_set = '0;
        first_set[BIT_INPUT_CHANGE] = input_change_req;
        first_set[BIT_PORT1_MASTER] = port1_master_req;
        first_set[BIT_PORT1_SLAVE] = port1_slave_req;
    end

    // request acted on only in the answer cycle, so it takes effect exactly once
    assign take = (state_reg.bus == BUS_ANSWER);
    assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_first = take && avs_write && (avs_address == ADDR_FIRST);
    assign wr_third = take && avs_write && (avs_address == ADDR_THIRD);

    flag_word #(.IMPL(FIRST_IMPL)) u_first (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_pulse(first_set),
        .wr_en(wr_first),
        .wr_data(avs_writedata[FLAG_W-1:0]),
        .wr_mask(lane_mask),
        .flags(first_flags),
        .rose(first_rose)
    );

    flag_word #(.IMPL(THIRD_IMPL)) u_third (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_pulse(third_req),
        .wr_en(wr_third),
        .wr_data(avs_writedata[FLAG_W-1:0]),
        .wr_mask(lane_mask),
        .flags(third_flags),
        .rose(third_rose)
    );

    always_comb begin
        state_next = state_reg;
        state_next.flags.first = first_flags;
        state_next.flags.third = third_flags;
        state_next.wait_n = 1'b0;
        // event bits are sticky; a new event beats the read clear
        // clear only what the read reported, so a bit set after capture is not lost
        if (take && avs_read && (avs_address == ADDR_EVENT)) begin
            state_next.events = state_reg.events & ~state_reg.rdata[EV_THIRD:EV_FIRST];
        end
        if (|first_rose) begin
            state_next.events[EV_FIRST] = 1'b1;
        end
        if (|third_rose) begin
            state_next.events[EV_THIRD] = 1'b1;
        end
        case (state_reg.bus)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next.bus = BUS_ANSWER;
                    state_next.wait_n = 1'b1;
                    if (avs_address == ADDR_FIRST) begin
                        state_next.rdata = {16'h0000, first_flags & FIRST_IMPL};
                    end else if (avs_address == ADDR_THIRD) begin
                        state_next.rdata = {16'h0000, third_flags & THIRD_IMPL};
                    end else if (avs_address == ADDR_EVENT) begin
                        state_next.rdata = {30'h0000_0000, state_reg.events};
                    end else if (avs_address == ADDR_MASK) begin
                        state_next.rdata = {30'h0000_0000, state_reg.mask};
                    end else begin
                        state_next.rdata = UNMAPPED_READ;
                    end
                end
            end
            BUS_ANSWER: begin
                state_next.bus = BUS_IDLE;
                if (avs_write && (avs_address == ADDR_MASK) && avs_byteenable[0]) begin
                    state_next.mask = avs_writedata[1:0];
                end
            end
            default: begin
                state_next.bus = BUS_IDLE;
            end
        endcase
        state_next.irq = |(state_next.events & state_next.mask);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg.bus <= BUS_IDLE;
            state_reg.rdata <= UNMAPPED_READ;
            state_reg.wait_n <= 1'b0;
            state_reg.events <= EVENT_RESET;
            state_reg.mask <= EVENT_RESET;
            state_reg.irq <= 1'b0;
            state_reg.flags <= '{first: FLAG_RESET, third: FLAG_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = ~state_reg.wait_n;
    assign flags_out = state_reg.flags;
    assign irq = state_reg.irq;
endmodule : flag_bank

// file: rtl/flag_word.sv
// one flag register: sticky set by sources, software write, unimplemented bits held at zero
`timescale 1ns/1ps
module flag_word #(
    parameter logic [flag_bank_pkg::FLAG_W-1:0] IMPL = '0
) (
    input wire logic core_clk, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [flag_bank_pkg::FLAG_W-1:0] set_pulse, // source requests
    input wire logic wr_en, // software write of this word
    input wire logic [flag_bank_pkg::FLAG_W-1:0] wr_data, // written value
    input wire logic [flag_bank_pkg::FLAG_W-1:0] wr_mask, // lanes being written
    output logic [flag_bank_pkg::FLAG_W-1:0] flags, // current flags
    output logic [flag_bank_pkg::FLAG_W-1:0] rose // flags newly set this edge
);
    import flag_bank_pkg::*;

    typedef struct packed {
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] rose;
    } word_state_s;

    word_state_s state_reg;
    word_state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.rose = '0;
        for (int i = 0; i < FLAG_W; i++) begin
            if (IMPL[i]) begin
                // set beats a simultaneous software clear so no request is lost
                if (set_pulse[i]) begin
                    state_next.flags[i] = 1'b1;
                    state_next.rose[i] = ~state_reg.flags[i];
                end else if (wr_en && wr_mask[i]) begin
                    state_next.flags[i] = wr_data[i];
                end
            end else begin
                state_next.flags[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= '{flags: FLAG_RESET, rose: FLAG_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;
    assign rose = state_reg.rose;
endmodule : flag_word

// file: testbench/flag_bank_props.sv
// checker: port-level assertions for the flag bank
`timescale 1ns/1ps
module flag_bank_props (
    input wire logic core_clk, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic avs_waitrequest, // stall
    input wire logic input_change_req, // source event
    input wire logic port1_master_req, // source event
    input wire logic port1_slave_req, // source event
    input wire logic [flag_bank_pkg::FLAG_W-1:0] third_req, // third sources
    input flag_bank_pkg::flag_pair_s flags_out // flags to processor
);
    import flag_bank_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_FIRST_GAP: assert property ((flags_out.first & ~FIRST_IMPL) == '0)
        else $error("unimplemented first flag bit set");
    AST_THIRD_GAP: assert property ((flags_out.third & ~THIRD_IMPL) == '0)
        else $error("unimplemented third flag bit set");
    // no write can complete while waitrequest is high, so the flag must survive
    AST_CHANGE_SET: assert property (input_change_req ##1 avs_waitrequest |=> flags_out.first[BIT_INPUT_CHANGE])
        else $error("input change flag not set");
    AST_MASTER_SET: assert property (port1_master_req ##1 avs_waitrequest |=> flags_out.first[BIT_PORT1_MASTER])
        else $error("port1 master flag not set");
    AST_SLAVE_SET: assert property (port1_slave_req ##1 avs_waitrequest |=> flags_out.first[BIT_PORT1_SLAVE])
        else $error("port1 slave flag not set");
    AST_THIRD_SET: assert property (third_req[0] ##1 avs_waitrequest |=> flags_out.third[0])
        else $error("third flag bit 0 not set");
    AST_RESET_CLR: assert property (disable iff (1'b0) !reset_n |=> flags_out == '0)
        else $error("flags not cleared by reset");
    AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("answer not in the cycle after request");
    AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer cycle longer than one");
endmodule : flag_bank_props

// file: testbench/flag_bank_tb.sv
// testbench: register access, source events, lanes and interrupt of the flag bank
`timescale 1ns/1ps
module flag_bank_tb;
    import flag_bank_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h3;
    logic [DATA_W-1:0] avs_readdata, q;
    logic avs_waitrequest, irq, ic_req, pm_req, ps_req;
    logic [FLAG_W-1:0] third_req;
    flag_pair_s flags_out;
    logic [18:0] fire_v = '0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    always #10 core_clk = ~core_clk;
    flag_sources u_src (.core_clk(core_clk), .fire(fire_v), .input_change_req(ic_req),
        .port1_master_req(pm_req), .port1_slave_req(ps_req), .third_req(third_req));
    flag_bank u_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .input_change_req(ic_req),
        .port1_master_req(pm_req), .port1_slave_req(ps_req), .third_req(third_req),
        .flags_out(flags_out), .irq(irq));
    task give_verdict;
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // entered just after a rising edge; at each edge the values of the ending cycle are seen,
    // so the request completes and read data is taken at the edge waitrequest is low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, '0, q);
        chk(q, e);
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic fire(input logic [18:0] v);
        fire_v <= v;
        @(posedge core_clk);
        fire_v <= '0;
        repeat (3) @(posedge core_clk);
    endtask : fire
    // irq is registered in the same edge as the event status; wait two edges, then sample at the falling edge
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge core_clk);
    endtask : chk_irq
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(ADDR_FIRST, '0);
        rd(ADDR_THIRD, '0);
        fire(19'h4_0000);
        rd(ADDR_FIRST, 32'h0000_0008);
        fire(19'h2_0000);
        rd(ADDR_FIRST, 32'h0000_000A);
        fire(19'h1_0000);
        rd(ADDR_FIRST, 32'h0000_000B);
        wr(ADDR_FIRST, '0);
        rd(ADDR_FIRST, '0);
        wr(ADDR_FIRST, 32'h0000_FFFF);
        rd(ADDR_FIRST, 32'h0000_000B);
        wr(ADDR_THIRD, 32'h0000_FFFF);
        rd(ADDR_THIRD, 32'h0000_39FF);
        wr(ADDR_THIRD, '0);
        fire(19'h0_FFFF);
        chk({16'h0000, flags_out.third}, 32'h0000_39FF);
        rd(ADDR_THIRD, 32'h0000_39FF);
        avs_byteenable <= 4'h1;
        wr(ADDR_THIRD, '0);
        avs_byteenable <= 4'h3;
        rd(ADDR_THIRD, 32'h0000_3900);
        wr(ADDR_THIRD, '0);
        wr(ADDR_FIRST, '0);
        wr(4'h7, 32'h0000_FFFF);
        rd(4'h7, '0);
        rd(ADDR_FIRST, '0);
        bus(1'b0, ADDR_EVENT, '0, q);
        fire(19'h0_0001);
        chk_irq(1'b0);
        wr(ADDR_MASK, 32'h0000_0002);
        rd(ADDR_MASK, 32'h0000_0002);
        chk_irq(1'b1);
        rd(ADDR_EVENT, 32'h0000_0002);
        chk_irq(1'b0);
        rd(ADDR_EVENT, '0);
        give_verdict();
    end
endmodule : flag_bank_tb
bind flag_bank flag_bank_props u_props (.core_clk(core_clk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .input_change_req(input_change_req), .port1_master_req(port1_master_req),
    .port1_slave_req(port1_slave_req), .third_req(third_req), .flags_out(flags_out));

// file: testbench/flag_sources.sv
// partner: peripheral event sources strobing the flag bank
`timescale 1ns/1ps
module flag_sources (
    input wire logic core_clk, // system clock
    input wire logic [18:0] fire, // events to raise: change, master, slave, third
    output logic input_change_req, // input change event
    output logic port1_master_req, // port1 master event
    output logic port1_slave_req, // port1 slave event
    output logic [flag_bank_pkg::FLAG_W-1:0] third_req // third register events
);
    // a peripheral strobes one cycle per event
    always_ff @(posedge core_clk) begin
        {input_change_req, port1_master_req, port1_slave_req, third_req} <= fire;
    end
endmodule : flag_sources
